// ---- rtl/sfl_pkg.sv ----
// Summary of operation
// - Launch output on falling, capture on rising clock
// - Clock level at select fall picks mode
// - Compatible timings: output valid during clock low
// - Full-cycle timings: host samples full cycle later
// - Write-protect acts within 1 us both ways
// - Sector lockdown completes within 200 us
// - Ultra-deep power-down reached within 3 us
// - Ultra-deep wake takes 240/120 us by supply
// - Deep power-down entered within 2 us
// - Resume from deep power-down within 35 us
// - Page to buffer transfer within 100 us
// - Page to buffer compare within 100 us
// - Erase and program page 35/25 ms
// - Security register program within 500 us
// - Each select fall samples idle clock level
// - Output high impedance after reset until a status read
package sfl_pkg;
  localparam int CLK_MHZ = 20;
  localparam int TMR_W = 20;
  // Completion times in their printed units
  localparam int T_WPE_US = 1;
  localparam int T_LOCK_US = 200;
  localparam int T_EUDPD_US = 3;
  localparam int T_EDPD_US = 2;
  localparam int T_RDPD_US = 35;
  localparam int T_XFR_US = 100;
  localparam int T_COMP_US = 100;
  localparam int T_EP_LO_MS = 35;
  localparam int T_EP_HI_MS = 25;
  localparam int T_OTPP_US = 500;
  localparam int T_XUDPD_LO_US = 240;
  localparam int T_XUDPD_HI_US = 120;
  // Longest times, rounded down to whole cycles
  localparam int CYC_WPE = T_WPE_US * CLK_MHZ;
  localparam int CYC_LOCK = T_LOCK_US * CLK_MHZ;
  localparam int CYC_EUDPD = T_EUDPD_US * CLK_MHZ;
  localparam int CYC_EDPD = T_EDPD_US * CLK_MHZ;
  localparam int CYC_RDPD = T_RDPD_US * CLK_MHZ;
  localparam int CYC_XFR = T_XFR_US * CLK_MHZ;
  localparam int CYC_COMP = T_COMP_US * CLK_MHZ;
  localparam int CYC_EP_LO = T_EP_LO_MS * 1000 * CLK_MHZ;
  localparam int CYC_EP_HI = T_EP_HI_MS * 1000 * CLK_MHZ;
  localparam int CYC_OTPP = T_OTPP_US * CLK_MHZ;
  localparam int CYC_XUDPD_LO = T_XUDPD_LO_US * CLK_MHZ;
  localparam int CYC_XUDPD_HI = T_XUDPD_HI_US * CLK_MHZ;
  // Opcodes
  localparam logic [7:0] OPC_DPD = 8'hB9;
  localparam logic [7:0] OPC_RESUME = 8'hAB;
  localparam logic [7:0] OPC_UDPD = 8'h79;
  localparam logic [7:0] OPC_STATUS = 8'hD7;
  localparam logic [7:0] OPC_XFER = 8'h53;
  localparam logic [7:0] OPC_COMP = 8'h60;
  localparam logic [7:0] OPC_EPROG = 8'h83;
  localparam logic [7:0] OPC_BUFWR = 8'h84;
  // Buffer write data follows opcode and three address bytes
  localparam logic [2:0] BUFWR_FIRST = 3'h4;
  // Status byte bit positions
  localparam int ST_READY = 7;
  localparam int ST_PROT = 1;
  localparam int ST_OVF = 0;
  // Synchroniser lanes
  localparam int SYNC_W = 5;
  localparam int IX_SCK = 0;
  localparam int IX_SI = 1;
  localparam int IX_CS = 2;
  localparam int IX_WP = 3;
  localparam int IX_SUP = 4;
  localparam logic [SYNC_W-1:0] SYNC_RST = 5'h0C;
  // Data buffer
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 32;
  localparam logic [TMR_W-1:0] TMR_RST = 20'h0_0000;
  typedef enum logic [4:0] {
    PW_STBY = 5'b00001,
    PW_BUSY = 5'b00010,
    PW_DPD = 5'b00100,
    PW_UDPD = 5'b01000,
    PW_WAKE = 5'b10000
  } sfl_pw_e;
endpackage

// ---- rtl/sfl_stream_if.sv ----
// Valid/ready byte stream between the link logic and the buffer
interface sfl_stream_if #(
  parameter int W = 8
);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

// ---- rtl/sfl_sync.sv ----
// Two-stage synchroniser plus a history stage for edge detection
module sfl_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q,
  output logic [W-1:0] q_prev
);
  logic [W-1:0] meta;

  // Meta stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta <= RST;
      q <= RST;
      q_prev <= RST;
    end else begin
      meta <= d;
      q <= meta;
      q_prev <= q;
    end
  end
endmodule

// ---- rtl/sfl_fifo.sv ----
// Buffer between received bytes and the memory write port
module sfl_fifo #(
  parameter int W = 8,
  parameter int D = 32
)(
  input wire logic clk,
  input wire logic rst_n,
  sfl_stream_if.snk in_s,
  sfl_stream_if.src out_s
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  // Honest flags from the fill count
  assign in_s.ready = (count != (AW+1)'(D));
  assign out_s.valid = (count != '0);
  assign out_s.data = mem[rd_ptr];
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;

  // Storage has no reset; only pointers and fill count need a defined value
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_s.data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ---- rtl/sfl_link_top.sv ----
// Serial slave of the flash: bit timing, command completion timers
module sfl_link_top
  import sfl_pkg::*;
#(
  parameter int P_LOCK = CYC_LOCK,
  parameter int P_EP_LO = CYC_EP_LO,
  parameter int P_EP_HI = CYC_EP_HI,
  parameter int P_OTPP = CYC_OTPP,
  parameter int P_XUDPD_LO = CYC_XUDPD_LO,
  parameter int P_XUDPD_HI = CYC_XUDPD_HI,
  parameter logic [7:0] OPC_LOCK = 8'hC1,
  parameter logic [7:0] OPC_OTP = 8'hC2
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sck,
  input wire logic si,
  input wire logic device_select_bar,
  input wire logic wp_bar,
  input wire logic supply_high,
  output logic so,
  output logic so_oe_n,
  output logic mode3,
  output logic protect,
  output logic busy,
  output logic power_deep,
  output logic power_ultra,
  output logic op_done,
  output logic overflow,
  output logic [7:0] wr_data,
  output logic wr_valid,
  input wire logic wr_ready
);
  logic [SYNC_W-1:0] pin_q;
  logic [SYNC_W-1:0] pin_prev;
  logic sck_q;
  logic si_q;
  logic cs_q;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;
  logic [7:0] shift_in;
  logic [7:0] next_byte;
  logic [2:0] bit_cnt;
  logic [2:0] byte_cnt;
  logic [7:0] opcode;
  logic byte_done;
  logic [7:0] tx_sh;
  logic tx_on;
  logic exec;
  sfl_pw_e pw;
  logic [TMR_W-1:0] tmr;
  logic [7:0] op_cur;
  logic [7:0] status;

  sfl_stream_if #(.W(FIFO_W)) in_s ();
  sfl_stream_if #(.W(FIFO_W)) out_s ();

  // Every pin crosses two flops before any logic looks at it
  sfl_sync #(.W(SYNC_W), .RST(SYNC_RST)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({supply_high, wp_bar, device_select_bar, si, sck}),
    .q(pin_q),
    .q_prev(pin_prev)
  );

  sfl_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_s(in_s),
    .out_s(out_s)
  );

  // Timer load for each timed operation; erase-program and ultra-deep wake picked by supply range
  function automatic logic [TMR_W-1:0] load_cycles(
    input logic [7:0] op,
    input logic hi
  );
    int c;
    c = 1;
    if (op == OPC_XFER) begin
      c = CYC_XFR;
    end else if (op == OPC_COMP) begin
      c = CYC_COMP;
    end else if (op == OPC_EPROG) begin
      c = hi ? P_EP_HI : P_EP_LO;
    end else if (op == OPC_LOCK) begin
      c = P_LOCK;
    end else if (op == OPC_OTP) begin
      c = P_OTPP;
    end else if (op == OPC_RESUME) begin
      c = CYC_RDPD;
    end else if (op == OPC_UDPD) begin
      c = hi ? P_XUDPD_HI : P_XUDPD_LO;
    end
    return TMR_W'(c);
  endfunction

  // Edges of the sampled link signals
  assign sck_q = pin_q[IX_SCK];
  assign si_q = pin_q[IX_SI];
  assign cs_q = pin_q[IX_CS];
  assign sck_rise = sck_q && !pin_prev[IX_SCK];
  assign sck_fall = !sck_q && pin_prev[IX_SCK];
  assign cs_fall = !cs_q && pin_prev[IX_CS];
  assign cs_rise = cs_q && !pin_prev[IX_CS];
  assign next_byte = {shift_in[6:0], si_q};
  assign byte_done = sck_rise && !cs_q && (bit_cnt == 3'h7);
  // A command counts only if it ended on a whole byte
  assign exec = cs_rise && (bit_cnt == 3'h0) && (byte_cnt != 3'h0);
  assign status = {!busy, 5'h00, protect, overflow};

  // Mode is the idle clock level at each select fall
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode3 <= 1'b0;
    end else if (cs_fall) begin
      mode3 <= sck_q;
    end
  end

  // Input bits are taken on rising clock edges only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shift_in <= 8'h00;
      bit_cnt <= 3'h0;
      byte_cnt <= 3'h0;
      opcode <= 8'h00;
    end else if (cs_fall) begin
      bit_cnt <= 3'h0;
      byte_cnt <= 3'h0;
    end else if (sck_rise && !cs_q) begin
      shift_in <= next_byte;
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_cnt == 3'h7) begin
        if (byte_cnt == 3'h0) begin
          opcode <= next_byte;
        end
        // Saturate so long data phases keep the last count
        if (byte_cnt != 3'h7) begin
          byte_cnt <= byte_cnt + 3'h1;
        end
      end
    end
  end

  // Buffer write bytes go to the FIFO after the address bytes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      in_s.valid <= 1'b0;
      in_s.data <= 8'h00;
    end else begin
      in_s.valid <= byte_done && (opcode == OPC_BUFWR)
        && (byte_cnt >= BUFWR_FIRST) && (pw == PW_STBY);
      in_s.data <= next_byte;
    end
  end

  // The host cannot be stalled, so a full buffer drops and flags
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      overflow <= 1'b0;
    end else if (in_s.valid && !in_s.ready) begin
      overflow <= 1'b1;
    end
  end

  // Output bits launch on falling edges; pin floats until a read
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_on <= 1'b0;
      tx_sh <= 8'h00;
      so <= 1'b0;
      so_oe_n <= 1'b1;
    end else if (cs_q) begin
      tx_on <= 1'b0;
      so_oe_n <= 1'b1;
    end else if (byte_done && byte_cnt == 3'h0
        && next_byte == OPC_STATUS && pw != PW_UDPD) begin
      tx_on <= 1'b1;
      tx_sh <= status;
    end else if (sck_fall && tx_on) begin
      so <= tx_sh[7];
      so_oe_n <= 1'b0;
      // Reload a fresh status at each byte boundary
      tx_sh <= (bit_cnt == 3'h0) ? {status[6:0], 1'b0}
        : {tx_sh[6:0], 1'b0};
      if (bit_cnt == 3'h0) begin
        so <= status[7];
      end
    end
  end

  // Protection follows the pin after the synchroniser
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      protect <= 1'b0;
    end else begin
      protect <= !pin_q[IX_WP];
    end
  end

  // Power and busy sequencing
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pw <= PW_STBY;
      tmr <= TMR_RST;
      op_cur <= 8'h00;
      op_done <= 1'b0;
    end else begin
      op_done <= 1'b0;
      case (pw)
        PW_STBY: begin
          if (exec) begin
            op_cur <= opcode;
            tmr <= load_cycles(opcode, pin_q[IX_SUP]);
            if (opcode == OPC_DPD) begin
              pw <= PW_DPD;
            end else if (opcode == OPC_UDPD) begin
              pw <= PW_UDPD;
            end else if (opcode == OPC_XFER || opcode == OPC_COMP
                || opcode == OPC_LOCK || opcode == OPC_OTP) begin
              pw <= PW_BUSY;
            end else if (opcode == OPC_EPROG && !protect) begin
              pw <= PW_BUSY;
            end
          end
        end
        PW_DPD: begin
          // Only the resume command leaves this state; status reads are still answered
          if (exec && opcode == OPC_RESUME) begin
            op_cur <= OPC_RESUME;
            tmr <= load_cycles(OPC_RESUME, pin_q[IX_SUP]);
            pw <= PW_WAKE;
          end
        end
        PW_UDPD: begin
          // Any sampled select low wakes; shorter pulses are missed
          if (cs_fall) begin
            op_cur <= OPC_UDPD;
            tmr <= load_cycles(OPC_UDPD, pin_q[IX_SUP]);
            pw <= PW_WAKE;
          end
        end
        PW_BUSY, PW_WAKE: begin
          if (tmr <= TMR_W'(1)) begin
            tmr <= TMR_RST;
            pw <= PW_STBY;
            op_done <= 1'b1;
          end else begin
            tmr <= tmr - TMR_W'(1);
          end
        end
        default: begin
          pw <= PW_STBY;
        end
      endcase
    end
  end

  // State outputs come from their own flops
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy <= 1'b0;
      power_deep <= 1'b0;
      power_ultra <= 1'b0;
    end else begin
      busy <= (pw == PW_BUSY) || (pw == PW_WAKE);
      power_deep <= (pw == PW_DPD);
      power_ultra <= (pw == PW_UDPD);
    end
  end

  // Output stage keeps the write port registered
  assign out_s.ready = !wr_valid || wr_ready;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_valid <= 1'b0;
      wr_data <= 8'h00;
    end else if (out_s.ready) begin
      wr_valid <= out_s.valid;
      wr_data <= out_s.data;
    end
  end

  // Helper for checks: cycles spent in the current timed state
  logic [TMR_W-1:0] busy_age;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_age <= TMR_RST;
    end else if (pw == PW_BUSY || pw == PW_WAKE) begin
      busy_age <= busy_age + TMR_W'(1);
    end else begin
      busy_age <= TMR_RST;
    end
  end

  localparam int A_WPE = CYC_WPE;
  localparam int A_EUDPD = CYC_EUDPD;
  localparam int A_EDPD = CYC_EDPD;
  localparam int A_RDPD = CYC_RDPD;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_udpd_cmd;
    exec && pw == PW_STBY && opcode == OPC_UDPD;
  endsequence
  sequence s_resume_cmd;
    exec && pw == PW_DPD && opcode == OPC_RESUME;
  endsequence

  chk_capture_rise: assert property (
    sck_rise && !cs_q |=> shift_in[0] == $past(si_q))
    else $error("input bit not taken on rising edge");
  chk_launch_fall: assert property (
    $changed(so) |-> $past(sck_fall))
    else $error("output changed away from a falling edge");
  chk_so_clk_low: assert property (
    $changed(so) |-> !sck_q && !so_oe_n)
    else $error("output changed while clock high");
  chk_mode_pick: assert property (
    cs_fall |=> mode3 == $past(sck_q) ##1 $stable(mode3))
    else $error("mode not taken from idle clock");
  chk_wp_follow: assert property (
    $changed(pin_q[IX_WP]) |-> ##[1:A_WPE] protect != pin_q[IX_WP])
    else $error("protection late after write-protect change");
  chk_udpd_entry: assert property (
    s_udpd_cmd |-> ##[1:A_EUDPD] power_ultra)
    else $error("ultra-deep power-down entry late");
  chk_dpd_entry: assert property (
    exec && pw == PW_STBY && opcode == OPC_DPD |-> ##[1:A_EDPD] power_deep)
    else $error("deep power-down entry late");
  chk_resume_time: assert property (
    s_resume_cmd |=> pw == PW_WAKE ##[1:A_RDPD] pw == PW_STBY)
    else $error("resume from deep power-down late");
  chk_busy_bound: assert property (
    (pw == PW_BUSY || pw == PW_WAKE)
      |-> busy_age < load_cycles(op_cur, pin_q[IX_SUP]))
    else $error("timed operation overran its limit");
  chk_so_reset: assert property (
    $rose(rst_n) |-> so_oe_n && !tx_on)
    else $error("output driven after reset");
endmodule

// ---- bench/sfl_host_model.sv ----
// Host side of the serial link: drives clock, data and select
module sfl_host_model (
  input wire logic clk,
  input wire logic so,
  input wire logic so_oe_n,
  output logic sck,
  output logic si,
  output logic device_select_bar,
  output logic [7:0] cap
);
  timeunit 1ns;
  timeprecision 1ns;
  logic idle_hi;
  logic so_line;

  // Start from an idle, deselected bus
  initial begin
    sck = 1'b0;
    si = 1'b0;
    device_select_bar = 1'b1;
    cap = 8'h00;
    idle_hi = 1'b0;
  end
  // Released output reads as the inverse of the last driven bit,
  // so a stale bit can never pass as data
  assign so_line = so_oe_n ? ~so : so;

  task automatic pause(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Idle clock level is set before select falls to pick the mode
  task automatic start(input logic hi);
    pause(8);
    sck <= hi;
    idle_hi = hi;
    pause(4);
    device_select_bar <= 1'b0;
    pause(4);
  endtask

  // Clock is 8 system cycles, so each half is 4 cycles
  // First bit is set up in the low half; later bits launch one cycle
  // after a rising edge and stand a full clock until the next one
  task automatic xfer(input logic [7:0] tx);
    for (int i = 0; i < 8; i++) begin
      sck <= 1'b0;
      cap <= {cap[6:0], so_line};
      pause(2);
      if (i == 0) begin
        si <= tx[7];
      end
      pause(2);
      sck <= 1'b1;
      pause(1);
      if (i < 7) begin
        si <= tx[6-i];
      end
      pause(3);
    end
  endtask

  // Bare select pulse, long enough for the device to sample it
  task automatic wake;
    pause(8);
    device_select_bar <= 1'b0;
    pause(4);
    device_select_bar <= 1'b1;
  endtask

  // Last falling edge only samples the bit launched after the previous falling edge
  task automatic finish;
    sck <= 1'b0;
    cap <= {cap[6:0], so_line};
    pause(4);
    sck <= idle_hi;
    pause(4);
    device_select_bar <= 1'b1;
    si <= ~si;
  endtask
endmodule

// ---- bench/sfl_link_top_test.sv ----
// Self-checking bench for the serial flash link
module sfl_link_top_test
  import sfl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int EP_LO = 100;
  localparam int EP_HI = 80;
  localparam int XU_LO = 40;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wp_bar = 1'b1;
  logic supply_high = 1'b0;
  logic wr_ready = 1'b0;
  logic sck, si, device_select_bar, so, so_oe_n, mode3, protect, busy;
  logic power_deep, power_ultra, op_done, overflow, wr_valid;
  logic [7:0] wr_data, cap, st;
  int bad_count = 0;
  int compares = 0;

  always #25 clk = ~clk;

  sfl_link_top #(.P_EP_LO(EP_LO), .P_EP_HI(EP_HI),
    .P_XUDPD_LO(XU_LO)) sfl_link_top_inst (
    .clk(clk), .rst_n(rst_n), .sck(sck), .si(si),
    .device_select_bar(device_select_bar), .wp_bar(wp_bar),
    .supply_high(supply_high), .so(so), .so_oe_n(so_oe_n), .mode3(mode3),
    .protect(protect), .busy(busy), .power_deep(power_deep),
    .power_ultra(power_ultra), .op_done(op_done), .overflow(overflow),
    .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready));

  sfl_host_model sfl_host_model_inst (.clk(clk), .so(so), .so_oe_n(so_oe_n),
    .sck(sck), .si(si), .device_select_bar(device_select_bar), .cap(cap));

  task automatic give_verdict;
    $display("counts: %0d compares, %0d mismatches", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic cmp_bit(input logic got, input logic exp, input string m);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: %s got %b", $time, m, got);
    end
  endtask

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp,
                          input string m);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask

  task automatic timeout(input string m);
    bad_count++;
    $display("ERROR at %0t: no end to %s", $time, m);
    give_verdict();
  endtask

  // Opcode, optional three address bytes, then select rises
  task automatic cmd(input logic [7:0] op, input bit addr);
    sfl_host_model_inst.start(1'b0);
    sfl_host_model_inst.xfer(op);
    if (addr) repeat (3) sfl_host_model_inst.xfer(8'h00);
    sfl_host_model_inst.finish();
  endtask

  task automatic read_status(input logic hi);
    sfl_host_model_inst.start(hi);
    sfl_host_model_inst.xfer(OPC_STATUS);
    sfl_host_model_inst.xfer(8'h00);
    sfl_host_model_inst.finish();
    st = cap;
  endtask

  // Waits for a flag; the bound adds a few cycles of pin synchroniser
  task automatic wait_lvl(input int sel, input logic lvl, input int lim);
    logic f;
    int k;
    for (k = 0; k < lim + 4; k++) begin
      @(negedge clk);
      f = (sel == 0) ? protect : (sel == 1) ? power_deep : power_ultra;
      if (f === lvl) break;
    end
    if (k >= lim + 4) timeout("flag wait");
  endtask

  // Counts busy cycles of one timed operation up to its done pulse
  task automatic wait_op(input int exp);
    int n;
    int k;
    n = 0;
    for (k = 0; k < exp + 200; k++) begin
      @(negedge clk);
      if (busy === 1'b1) n++;
      if (op_done === 1'b1) break;
    end
    if (k >= exp + 200) timeout("busy");
    cmp_bit(n >= exp - 1 && n <= exp + 1, 1'b1, "busy length");
    @(negedge clk);
    cmp_bit(busy, 1'b0, "busy after done");
  endtask

  task automatic t_reset;
    @(negedge clk);
    cmp_bit(so_oe_n, 1'b1, "output enable");
    cmp_bit(busy | power_deep | power_ultra | overflow, 1'b0, "flags");
    cmp_bit(wr_valid, 1'b0, "write valid");
    $display("test reset done");
  endtask

  task automatic t_status(input logic hi);
    read_status(hi);
    cmp_bit(mode3, hi, "mode");
    cmp_byte(st, 8'h80, "status");
    repeat (6) @(negedge clk);
    cmp_bit(so_oe_n, 1'b1, "release");
    $display("test status mode %b done", hi);
  endtask

  task automatic t_protect;
    @(posedge clk) wp_bar <= 1'b0;
    wait_lvl(0, 1'b1, CYC_WPE);
    read_status(1'b0);
    cmp_byte(st, 8'h82, "protected status");
    @(posedge clk) wp_bar <= 1'b1;
    wait_lvl(0, 1'b0, CYC_WPE);
    $display("test protect done");
  endtask

  // One entry per timed command, erase-program once per supply: opcode, cycles; index sets address flag and supply
  task automatic t_timed;
    logic [7:0] ops[6] = '{OPC_XFER, OPC_COMP, OPC_EPROG, OPC_EPROG,
                           8'hC1, 8'hC2};
    int cyc[6] = '{CYC_XFR, CYC_COMP, EP_LO, EP_HI, CYC_LOCK, CYC_OTPP};
    for (int i = 0; i < 6; i++) begin
      @(posedge clk) supply_high <= (i == 3);
      cmd(ops[i], i < 4);
      wait_op(cyc[i]);
    end
    @(posedge clk) supply_high <= 1'b0;
    $display("test timed commands done");
  endtask

  task automatic t_power;
    cmd(OPC_DPD, 1'b0);
    wait_lvl(1, 1'b1, CYC_EDPD);
    cmd(OPC_RESUME, 1'b0);
    wait_op(CYC_RDPD);
    cmp_bit(power_deep, 1'b0, "deep exit");
    cmd(OPC_UDPD, 1'b0);
    wait_lvl(2, 1'b1, CYC_EUDPD);
    sfl_host_model_inst.wake();
    wait_op(XU_LO);
    cmp_bit(power_ultra, 1'b0, "ultra exit");
    $display("test power-down done");
  endtask

  // Fill the buffer with the sink stalled, then drain it in order
  task automatic t_fifo;
    int n;
    n = 0;
    sfl_host_model_inst.start(1'b0);
    sfl_host_model_inst.xfer(OPC_BUFWR);
    repeat (3) sfl_host_model_inst.xfer(8'h00);
    for (int i = 0; i < 34; i++) sfl_host_model_inst.xfer(8'(i));
    sfl_host_model_inst.finish();
    repeat (8) @(negedge clk);
    cmp_bit(overflow, 1'b1, "overflow");
    @(posedge clk) wr_ready <= 1'b1;
    repeat (100) begin
      @(negedge clk);
      if (wr_valid === 1'b1) begin
        cmp_byte(wr_data, 8'(n), "drained byte");
        n++;
      end
    end
    cmp_bit(n == 33, 1'b1, "drained count");
    read_status(1'b0);
    cmp_byte(st, 8'h81, "overflow status");
    $display("test buffer done");
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_status(1'b0);
    t_status(1'b1);
    t_protect();
    t_timed();
    t_power();
    t_fifo();
    give_verdict();
  end
endmodule
